// File: shared/scpa_defines.svh
// Constants for the system control port A register block.
// Contract
// - Decode I/O address 0x0092 as the port.
// - Bit 3 set blocks secured password access.
// - Bit 3 clears only on power cycle.
// - Bit 3 reads back; firmware sets it.
// - Bit 1 high passes address line twenty.
// - Bit 1 low forces line twenty inactive; the code does so only while real_mode_i is high.
// - System reset clears bit 1.
`ifndef SCPA_DEFINES_SVH
`define SCPA_DEFINES_SVH

`define SCPA_PORT_ADDR    16'h0092
`define SCPA_LOCK_BIT     3
`define SCPA_GATE_BIT     1
`define SCPA_PWD_BASE     6'h38
`define SCPA_PWD_BYTES    6'h08
`define SCPA_LOCK_RESET   1'h0
`define SCPA_GATE_RESET   1'h0

`endif

// File: shared/scpa_pkg.sv
// Types for the system control port A register block.
`default_nettype none
package scpa_pkg;
  typedef logic [15:0] scpa_addr_t;
  typedef logic [7:0]  scpa_data_t;
  typedef logic [5:0]  scpa_cmos_addr_t;
endpackage
`default_nettype wire

// File: rtl/scpa_system_control_a.sv
// System control port A: password lock latch and address line twenty gate.
`include "scpa_defines.svh"
`default_nettype none
module scpa_system_control_a (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     por_nrst_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     io_rd_i,
  input  wire logic                     io_wr_i,
  input  wire scpa_pkg::scpa_addr_t     io_addr_i,
  input  wire scpa_pkg::scpa_data_t     io_wdata_i,
  input  wire logic                     cpu_a20_i,
  input  wire logic                     real_mode_i,
  input  wire scpa_pkg::scpa_cmos_addr_t cmos_addr_i,
  output logic                          io_sel_o,
  output scpa_pkg::scpa_data_t          io_rdata_o,
  output logic                          a20_o,
  output logic                          pwd_block_o,
  output logic                          address_line_twenty_pass_o
);
  import scpa_pkg::*;

  logic       lock_q;
  logic       gate_q;
  logic       sel_q;
  scpa_data_t rdata_q;
  logic       a20_q;
  logic       block_q;

  wire        hit      = (io_addr_i == `SCPA_PORT_ADDR);
  wire        wr_hit   = clk_en_i & io_wr_i & hit;
  wire        rd_hit   = clk_en_i & io_rd_i & hit;
  // One extra bit keeps the end of the password window from wrapping to zero at the
  // top of the CMOS index space, which would otherwise switch the block off for good.
  wire [6:0]  pwd_idx  = {1'h0, cmos_addr_i};
  wire [6:0]  pwd_lo   = {1'h0, `SCPA_PWD_BASE};
  wire [6:0]  pwd_hi   = pwd_lo + {1'h0, `SCPA_PWD_BYTES};
  wire        in_pwd   = (pwd_idx >= pwd_lo) && (pwd_idx < pwd_hi);
  wire scpa_data_t port_val;

  // Reserved bits are built from zeros so they can never hold a written value.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_port_bit
      if (gi == `SCPA_LOCK_BIT)
      begin : g_lock
        assign port_val[gi] = lock_q;
      end
      else if (gi == `SCPA_GATE_BIT)
      begin : g_gate
        assign port_val[gi] = gate_q;
      end
      else
      begin : g_rsvd
        assign port_val[gi] = 1'h0;
      end
    end
  endgenerate
  wire        a20_d    = real_mode_i ? (cpu_a20_i & gate_q) : cpu_a20_i;

  // The lock lives only on the power-on reset so a system reset cannot unlock it.
  always_ff @(posedge ref_clk_i or negedge por_nrst_i)
  begin
    if (!por_nrst_i)
      lock_q <= `SCPA_LOCK_RESET;
    else if (wr_hit && io_wdata_i[`SCPA_LOCK_BIT])
      lock_q <= 1'h1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      gate_q <= `SCPA_GATE_RESET;
    else if (wr_hit)
      gate_q <= io_wdata_i[`SCPA_GATE_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sel_q   <= 1'h0;
      rdata_q <= 8'h00;
      a20_q   <= 1'h0;
      block_q <= 1'h0;
    end
    else if (clk_en_i)
    begin
      sel_q   <= rd_hit;
      rdata_q <= rd_hit ? port_val : 8'h00;
      a20_q   <= a20_d;
      block_q <= lock_q & in_pwd;
    end
  end

  // Each output is a flop, so the partner sees clean levels; the price is one cycle of
  // latency on address line twenty, which the processor timing has to absorb.
  assign io_sel_o                   = sel_q;
  assign io_rdata_o                 = rdata_q;
  assign a20_o                      = a20_q;
  assign pwd_block_o                = block_q;
  assign address_line_twenty_pass_o = gate_q;

  property p_gate_forces_a20;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && real_mode_i && !gate_q) |=> !a20_o;
  endproperty
  a_gate_forces_a20: assert property (p_gate_forces_a20) else $error("a20 not forced low");

  property p_gate_passes_a20;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && gate_q) |=> (a20_o == $past(cpu_a20_i));
  endproperty
  a_gate_passes_a20: assert property (p_gate_passes_a20) else $error("a20 not passed");

  property p_lock_sticky;
    @(posedge ref_clk_i) disable iff (!por_nrst_i)
      lock_q |=> lock_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock latch cleared");

  property p_block_pwd;
    @(posedge ref_clk_i) disable iff (!nrst_i || !por_nrst_i)
      (clk_en_i && lock_q && in_pwd) |=> pwd_block_o;
  endproperty
  a_block_pwd: assert property (p_block_pwd) else $error("password not blocked");

  property p_read_value;
    @(posedge ref_clk_i) disable iff (!nrst_i || !por_nrst_i)
      rd_hit |=> (io_sel_o && io_rdata_o[3] == $past(lock_q)
                  && io_rdata_o[1] == $past(gate_q));
  endproperty
  a_read_value: assert property (p_read_value) else $error("bad port read");

  property p_reserved_zero;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      io_sel_o |-> (io_rdata_o[7:4] == 4'h0 && !io_rdata_o[2] && !io_rdata_o[0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_no_decode_miss;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && io_wr_i && !hit) |=> $stable(gate_q);
  endproperty
  a_no_decode_miss: assert property (p_no_decode_miss) else $error("gate moved off port");

  property p_write_gate;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      wr_hit |=> (gate_q == $past(io_wdata_i[1]));
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("gate write lost");

  // A write or a read is one step on the bus, and the answer follows one cycle later.
  sequence s_lock_write;
    wr_hit && io_wdata_i[`SCPA_LOCK_BIT];
  endsequence

  sequence s_gate_open;
    wr_hit && io_wdata_i[`SCPA_GATE_BIT];
  endsequence

  sequence s_read_once;
    rd_hit ##1 (clk_en_i && !rd_hit);
  endsequence

  property p_lock_write;
    @(posedge ref_clk_i) disable iff (!por_nrst_i)
      s_lock_write |=> lock_q;
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock write lost");

  property p_lock_needs_write;
    @(posedge ref_clk_i) disable iff (!por_nrst_i)
      (!lock_q && !(wr_hit && io_wdata_i[`SCPA_LOCK_BIT])) |=> !lock_q;
  endproperty
  a_lock_needs_write: assert property (p_lock_needs_write) else $error("lock rose");

  property p_open_then_pass;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (s_gate_open ##1 (clk_en_i && real_mode_i)) |=> (a20_o == $past(cpu_a20_i));
  endproperty
  a_open_then_pass: assert property (p_open_then_pass) else $error("a20 held");

  property p_read_pulse;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_read_once |=> (!io_sel_o && io_rdata_o == 8'h00);
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read answer held");

  property p_sel_needs_read;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && !rd_hit) |=> !io_sel_o;
  endproperty
  a_sel_needs_read: assert property (p_sel_needs_read) else $error("stray select");

  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && !rd_hit) |=> (io_rdata_o == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("data without read");

  property p_block_release;
    @(posedge ref_clk_i) disable iff (!nrst_i || !por_nrst_i)
      (clk_en_i && !(lock_q && in_pwd)) |=> !pwd_block_o;
  endproperty
  a_block_release: assert property (p_block_release) else $error("needless block");

  property p_a20_outside_real;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (clk_en_i && !real_mode_i) |=> (a20_o == $past(cpu_a20_i));
  endproperty
  a_a20_outside_real: assert property (p_a20_outside_real) else $error("a20 gated");

  // The check looks one edge later so that the flops have surely taken their reset values.
  property p_reset_clears;
    @(posedge ref_clk_i)
      !nrst_i |=> (!address_line_twenty_pass_o && !io_sel_o && !a20_o && !pwd_block_o);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("state kept in reset");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (!nrst_i || !por_nrst_i)
      !clk_en_i |=> ($stable(lock_q) && $stable(gate_q)
                     && $stable(io_sel_o) && $stable(a20_o));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // scpa_system_control_a
`default_nettype wire

// File: bench/scpa_cpu_model.sv
// Processor model that issues single byte I/O cycles to the port.
`default_nettype none
module scpa_cpu_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {rd_o, wr_o, addr_o, wdata_o} = '0;
  end
  // Released lines carry the inverse so a stale value is never mistaken for a request.
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i) {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i) {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_i) {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i) {rd_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
  endtask
endmodule // scpa_cpu_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for system control port A.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scpa_pkg::*;
  logic            ref_clk_i = 1'b0, nrst_i = 1'b0, por_nrst_i = 1'b0;
  logic            cpu_a20_i = 1'b0, real_mode_i = 1'b1, clk_en = 1'b1;
  scpa_cmos_addr_t cmos_addr_i = 6'h00;
  wire logic       rd, wr, sel, a20, blk, pass;
  wire scpa_addr_t addr;
  wire scpa_data_t wdata, rdata;
  int              error_cnt = 0, check_count = 0, cyc = 0;
  scpa_cpu_model u_cpu (.clk_i(ref_clk_i), .rdata_i(rdata), .rd_o(rd), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata));
  scpa_system_control_a u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .por_nrst_i(por_nrst_i), .clk_en_i(clk_en), .io_rd_i(rd), .io_wr_i(wr),
    .io_addr_i(addr), .io_wdata_i(wdata), .cpu_a20_i(cpu_a20_i),
    .real_mode_i(real_mode_i), .cmos_addr_i(cmos_addr_i), .io_sel_o(sel),
    .io_rdata_o(rdata), .a20_o(a20), .pwd_block_o(blk), .address_line_twenty_pass_o(pass));
  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] e);
    logic [7:0] d;
    u_cpu.io_rd(16'h0092, d);
    chk("port", e, d);
    chk("sel", 8'h01, {7'h00, sel});
  endtask
  task automatic t_gate_lock();
    rd_chk(8'h00);
    @(negedge ref_clk_i) cpu_a20_i = 1'b1;
    @(negedge ref_clk_i) chk("a20_off", 8'h00, {7'h00, a20});
    @(negedge ref_clk_i) real_mode_i = 1'b0;
    @(negedge ref_clk_i) chk("a20_prot", 8'h01, {7'h00, a20});
    real_mode_i = 1'b1;
    u_cpu.io_wr(16'h0092, 8'hFF);
    rd_chk(8'h0A);
    chk("a20_on", 8'h01, {7'h00, a20 & pass});
    @(negedge ref_clk_i) cmos_addr_i = 6'h37;
    @(negedge ref_clk_i) chk("blk_lo", 8'h00, {7'h00, blk});
    cmos_addr_i = 6'h3F;
    @(negedge ref_clk_i) chk("blk", 8'h01, {7'h00, blk});
    u_cpu.io_wr(16'h0093, 8'h00);
    rd_chk(8'h0A);
    u_cpu.io_wr(16'h0092, 8'h00);
    rd_chk(8'h08);
    $display("Test gate_lock done");
  endtask
  task automatic t_resets();
    @(negedge ref_clk_i) clk_en = 1'b0;
    u_cpu.io_wr(16'h0092, 8'h02);
    @(negedge ref_clk_i) clk_en = 1'b1;
    rd_chk(8'h08);
    u_cpu.io_wr(16'h0092, 8'h02);
    @(negedge ref_clk_i) nrst_i = 1'b0;
    @(negedge ref_clk_i) nrst_i = 1'b1;
    rd_chk(8'h08);
    @(negedge ref_clk_i) por_nrst_i = 1'b0;
    @(negedge ref_clk_i) por_nrst_i = 1'b1;
    rd_chk(8'h00);
    $display("Test resets done");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    {nrst_i, por_nrst_i} = 2'b11;
    t_gate_lock();
    t_resets();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
